/* i2s_audio_port.sv */
// Dual two-channel serial audio port, each port master or slave on its own.
// Assumes one system clock at 25 MHz, synchronous reset, and that the
// surrounding pad logic resolves the bit clock and word select pins from
// the output enables.
`timescale 1ns/1ps

// Summary of operation
// - Two independent ports, each with own clock, word select, data out and in.
// - Master drives bit clock and word select; slave takes both as inputs.
// - Serial data out is always driven as an output.
// - Each channel word is 16 bits, most significant bit first.
// - Left word MSB sits in the second bit slot of the frame, after the last right bit.
// - Word MSB appears one bit clock after each word select change, on a fall.
// - Left channel while word select is low, right while high.
// - Outgoing data changes only on falling bit clock edges.
// - Master short format is 32 bit clocks per frame at 48 kHz.
// - Master long format is 50 bit clocks per frame at 48 kHz.
// - Master bit clock comes from the reference by an N/M divider.
// - Slave accepts any bit clock up to 3.072 MHz.
// - Master bit clock high and low phases each at least 0.35 period.
module i2s_audio_port #(
    parameter int unsigned PORTS = i2s_audio_pkg::NUM_PORTS
) (
    input wire logic clock,
    input wire logic srst,
    input wire i2s_audio_pkg::port_cfg_s [PORTS-1:0] cfg,
    input wire i2s_audio_pkg::stereo_s [PORTS-1:0] tx_sample,
    output logic [PORTS-1:0] tx_taken,
    output i2s_audio_pkg::stereo_s [PORTS-1:0] rx_sample,
    output logic [PORTS-1:0] rx_valid,
    input wire logic [PORTS-1:0] sck_in,
    output logic [PORTS-1:0] sck_out,
    output logic [PORTS-1:0] sck_oe,
    input wire logic [PORTS-1:0] ws_in,
    output logic [PORTS-1:0] ws_out,
    output logic [PORTS-1:0] ws_oe,
    input wire logic [PORTS-1:0] sdi,
    output logic [PORTS-1:0] sdo
);

    // Refuse settings the logic cannot serve.
    if (PORTS < 1) begin : g_bad_ports
        $error("PORTS must be at least one");
    end
    if (i2s_audio_pkg::DIV_N_LONG >= i2s_audio_pkg::DIV_M) begin : g_bad_div
        $error("Reference clock too slow for the long frame format");
    end
    if (i2s_audio_pkg::SLAVE_MIN_PERIOD_CYC < 6) begin : g_bad_slave
        $error("Reference clock too slow to follow the slave bit clock");
    end
    if (i2s_audio_pkg::HALF_SHORT < 6'(i2s_audio_pkg::WORD_BITS)) begin : g_bad_word
        $error("Word does not fit in a half frame");
    end

    // Returns the next rx shift value, taking a bit only inside the word.
    function automatic logic [i2s_audio_pkg::WORD_BITS-1:0] rx_shift(
        input logic [i2s_audio_pkg::WORD_BITS-1:0] sh,
        input logic [4:0] cnt,
        input logic bit_in
    );
        logic [i2s_audio_pkg::WORD_BITS-1:0] res;
        res = sh;
        if (cnt < i2s_audio_pkg::WORD_CNT) begin
            res = {sh[i2s_audio_pkg::WORD_BITS-2:0], bit_in};
        end
        return res;
    endfunction : rx_shift

    // Saturating increment of a bit counter at the word length.
    function automatic logic [4:0] cnt_inc(input logic [4:0] cnt);
        logic [4:0] res;
        res = cnt;
        if (cnt < i2s_audio_pkg::WORD_CNT) begin
            res = cnt + 5'h01;
        end
        return res;
    endfunction : cnt_inc

    // One identical, independent engine per port.
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        i2s_audio_pkg::port_state_s st_r;
        i2s_audio_pkg::port_state_s st_nxt;
        logic sck_sync;
        logic ws_sync;
        logic sdi_sync;

        // Pin inputs cross into the clock domain through filtered chains.
        pin_sync u_sck_sync (
            .clock(clock),
            .srst(srst),
            .pin(sck_in[p]),
            .level(sck_sync)
        );
        pin_sync u_ws_sync (
            .clock(clock),
            .srst(srst),
            .pin(ws_in[p]),
            .level(ws_sync)
        );
        pin_sync u_sdi_sync (
            .clock(clock),
            .srst(srst),
            .pin(sdi[p]),
            .level(sdi_sync)
        );

        // Computes divider, framing, receive and transmit next state.
        always_comb begin
            logic [i2s_audio_pkg::ACC_W-1:0] step;
            logic [i2s_audio_pkg::ACC_W:0] sum;
            logic [5:0] half;
            logic rise;
            logic fall;
            logic ws_now;
            logic [i2s_audio_pkg::WORD_BITS-1:0] word;
            step = '0;
            sum = '0;
            half = '0;
            rise = 1'b0;
            fall = 1'b0;
            ws_now = 1'b0;
            word = '0;
            st_nxt = st_r;
            st_nxt.rx_valid = 1'b0;
            st_nxt.tx_take = 1'b0;
            st_nxt.sck_prev = sck_sync;

            // Pick the divider step and half-frame length for the format.
            if (cfg[p].frame_long) begin
                step = i2s_audio_pkg::DIV_N_LONG;
                half = i2s_audio_pkg::HALF_LONG;
            end else begin
                step = i2s_audio_pkg::DIV_N_SHORT;
                half = i2s_audio_pkg::HALF_SHORT;
            end

            if (cfg[p].master) begin
                // Accumulate N per cycle and toggle the clock on each wrap of M.
                sum = {1'b0, st_r.acc} + {1'b0, step};
                if (sum >= {1'b0, i2s_audio_pkg::DIV_M}) begin
                    st_nxt.acc = i2s_audio_pkg::ACC_W'(sum - {1'b0, i2s_audio_pkg::DIV_M});
                    st_nxt.bck = ~st_r.bck;
                    rise = ~st_r.bck;
                    fall = st_r.bck;
                end else begin
                    st_nxt.acc = sum[i2s_audio_pkg::ACC_W-1:0];
                end
                ws_now = st_r.ws;
            end else begin
                // Follow the external clock; edges seen on the filtered level.
                st_nxt.acc = '0;
                st_nxt.bck = sck_sync;
                rise = sck_sync & ~st_r.sck_prev;
                fall = ~sck_sync & st_r.sck_prev;
                ws_now = ws_sync;
            end

            // Master word select toggles after each half frame of falls.
            if (cfg[p].master && fall) begin
                if (st_r.hcnt >= half - 6'h01) begin
                    st_nxt.hcnt = '0;
                    st_nxt.ws = ~st_r.ws;
                end else begin
                    st_nxt.hcnt = st_r.hcnt + 6'h01;
                end
            end else if (!cfg[p].master) begin
                st_nxt.hcnt = '0;
                st_nxt.ws = ws_sync;
            end

            // Rising edge: sample data and word select, close words on change.
            if (rise) begin
                word = rx_shift(st_r.rx_sh, st_r.rx_cnt, sdi_sync);
                st_nxt.rx_sh = word;
                st_nxt.rx_cnt = cnt_inc(st_r.rx_cnt);
                st_nxt.ws_prev = ws_now;
                if (ws_now != st_r.ws_prev) begin
                    st_nxt.rx_cnt = '0;
                    if (!st_r.ws_prev) begin
                        st_nxt.rx.left = word;
                    end else begin
                        st_nxt.rx.right = word;
                        st_nxt.rx_valid = 1'b1;
                    end
                    // Load the word whose MSB leaves on the next fall.
                    st_nxt.tx_cnt = '0;
                    if (!ws_now) begin
                        st_nxt.tx_sh = tx_sample[p].left;
                        st_nxt.right_hold = tx_sample[p].right;
                        st_nxt.tx_take = 1'b1;
                    end else begin
                        st_nxt.tx_sh = st_r.right_hold;
                    end
                end
            end

            // Falling edge: launch the next data bit, zeros past the word.
            if (fall) begin
                if (st_r.tx_cnt < i2s_audio_pkg::WORD_CNT) begin
                    st_nxt.sdo = st_r.tx_sh[i2s_audio_pkg::WORD_BITS-1];
                    st_nxt.tx_sh = {st_r.tx_sh[i2s_audio_pkg::WORD_BITS-2:0], 1'b0};
                    st_nxt.tx_cnt = cnt_inc(st_r.tx_cnt);
                end else begin
                    st_nxt.sdo = 1'b0;
                end
            end
        end

        // Registers the port state; word select idles low, so left comes first.
        always_ff @(posedge clock) begin
            if (srst) begin
                st_r <= '0;
            end else begin
                st_r <= st_nxt;
            end
        end

        // Pin and user-side outputs from flip-flops; the pin enables come straight from cfg.
        assign sck_out[p] = st_r.bck;
        assign sck_oe[p] = cfg[p].master;
        assign ws_out[p] = st_r.ws;
        assign ws_oe[p] = cfg[p].master;
        assign sdo[p] = st_r.sdo;
        assign rx_sample[p] = st_r.rx;
        assign rx_valid[p] = st_r.rx_valid;
        assign tx_taken[p] = st_r.tx_take;
    end

endmodule : i2s_audio_port

/* i2s_audio_pkg.sv */
// Shared constants and carrier types for the dual serial audio port.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package i2s_audio_pkg;

    // System clock rate and audio frame rate in hertz.
    localparam int unsigned REF_CLK_HZ = 25_000_000;
    localparam int unsigned FRAME_RATE_HZ = 48_000;

    // Number of audio ports and bits in each channel word.
    localparam int unsigned NUM_PORTS = 2;
    localparam int unsigned WORD_BITS = 16;

    // Bit clocks per stereo frame for the two master formats.
    localparam int unsigned FRAME_BITS_SHORT = 32;
    localparam int unsigned FRAME_BITS_LONG = 50;

    // Highest slave bit clock rate in hertz and its period in cycles.
    localparam int unsigned SLAVE_MAX_HZ = 3_072_000;
    localparam int unsigned SLAVE_MIN_PERIOD_CYC = REF_CLK_HZ / SLAVE_MAX_HZ;

    // Phase accumulator width and step sizes for the N/M bit clock divider.
    localparam int unsigned ACC_W = 26;
    localparam logic [ACC_W-1:0] DIV_M = ACC_W'(REF_CLK_HZ);
    localparam logic [ACC_W-1:0] DIV_N_SHORT = ACC_W'(2 * FRAME_RATE_HZ * FRAME_BITS_SHORT);
    localparam logic [ACC_W-1:0] DIV_N_LONG = ACC_W'(2 * FRAME_RATE_HZ * FRAME_BITS_LONG);

    // Half-frame lengths in bit clocks, used for word select toggling.
    localparam logic [5:0] HALF_SHORT = 6'(FRAME_BITS_SHORT / 2);
    localparam logic [5:0] HALF_LONG = 6'(FRAME_BITS_LONG / 2);

    // Bit counter saturation value, equal to the word length.
    localparam logic [4:0] WORD_CNT = 5'(WORD_BITS);

    // Per-port configuration.
    typedef struct packed {
        logic master;
        logic frame_long;
    } port_cfg_s;

    // One stereo sample pair.
    typedef struct packed {
        logic [WORD_BITS-1:0] left;
        logic [WORD_BITS-1:0] right;
    } stereo_s;

    // Complete register state of one port.
    typedef struct packed {
        logic bck;
        logic [ACC_W-1:0] acc;
        logic ws;
        logic [5:0] hcnt;
        logic ws_prev;
        logic sck_prev;
        logic [WORD_BITS-1:0] rx_sh;
        logic [4:0] rx_cnt;
        logic [WORD_BITS-1:0] tx_sh;
        logic [4:0] tx_cnt;
        logic [WORD_BITS-1:0] right_hold;
        logic sdo;
        stereo_s rx;
        logic rx_valid;
        logic tx_take;
    } port_state_s;

endpackage : i2s_audio_pkg

/* pin_sync.sv */
// Three-stage input synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clock; the output follows a change only
// once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync (
    input wire logic clock,
    input wire logic srst,
    input wire logic pin,
    output logic level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic s1_nxt;
    logic s2_nxt;
    logic s3_nxt;
    logic level_nxt;

    // Shift the pin through the chain and update the filtered level on agreement.
    always_comb begin
        s1_nxt = pin;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    end

    // Register the chain; the first stage feeds only the second.
    always_ff @(posedge clock) begin
        if (srst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;

endmodule : pin_sync

/* i2s_audio_properties.sv */
// Checker for the master link timing of port 0 of the dual audio port.
// Assumes port 0 is master whenever its checks are meant to apply.
`timescale 1ns/1ps
module i2s_audio_properties #(
    parameter int unsigned PORTS = 2
) (
    input wire logic clock,
    input wire logic srst,
    input wire i2s_audio_pkg::port_cfg_s [PORTS-1:0] cfg,
    input wire logic [PORTS-1:0] tx_taken,
    input wire logic [PORTS-1:0] rx_valid,
    input wire logic [PORTS-1:0] sck_out,
    input wire logic [PORTS-1:0] sck_oe,
    input wire logic [PORTS-1:0] ws_out,
    input wire logic [PORTS-1:0] ws_oe,
    input wire logic [PORTS-1:0] sdo
);
    logic sck_q_r, sck_q_nxt, ws_q_r, ws_q_nxt, fall_q_r, fall;
    logic [5:0] fcnt_r, fcnt_nxt;
    logic [3:0] run_r, run_nxt;
    // Edge trackers, falls since the last word select change, phase length.
    always_comb begin
        fall = sck_q_r & ~sck_out[0];
        sck_q_nxt = sck_out[0];
        ws_q_nxt = ws_out[0];
        fcnt_nxt = fcnt_r;
        if (fall) begin
            fcnt_nxt = (ws_out[0] != ws_q_r) ? 6'h00 : fcnt_r + 6'h01;
        end
        run_nxt = (sck_out[0] != sck_q_r) ? 4'h1 : run_r + 4'h1;
    end
    // Registers the trackers; reset values match the idle pins.
    always_ff @(posedge clock) begin
        if (srst) begin
            sck_q_r <= 1'b0;
            ws_q_r <= 1'b0;
            fall_q_r <= 1'b0;
            fcnt_r <= 6'h00;
            run_r <= 4'h1;
        end else begin
            sck_q_r <= sck_q_nxt;
            ws_q_r <= ws_q_nxt;
            fall_q_r <= fall;
            fcnt_r <= fcnt_nxt;
            run_r <= run_nxt;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst || !cfg[0].master);
    // A left half frame starts when word select falls.
    sequence s_left_start;
        $fell(ws_out[0]);
    endsequence
    property p_oe;
        sck_oe == {cfg[1].master, cfg[0].master} && ws_oe == sck_oe;
    endproperty
    property p_ws_fall;
        $changed(ws_out[0]) |-> fall;
    endproperty
    property p_half;
        fall && (ws_out[0] != ws_q_r) |-> fcnt_r + 6'h01 ==
            (cfg[0].frame_long ? i2s_audio_pkg::HALF_LONG : i2s_audio_pkg::HALF_SHORT);
    endproperty
    property p_sdo_fall;
        $changed(sdo[0]) |-> fall || fall_q_r;
    endproperty
    property p_phase;
        (sck_out[0] != sck_q_r) |-> run_r >= (cfg[0].frame_long ? 4'h5 : 4'h8);
    endproperty
    property p_take;
        s_left_start |-> ##[1:12] tx_taken[0];
    endproperty
    property p_pair;
        s_left_start |-> ##[1:12] rx_valid[0];
    endproperty
    property p_pad;
        cfg[0].frame_long && !fall && fcnt_r >= 6'h11 |-> sdo[0] == 1'b0;
    endproperty
    a_oe: assert property (p_oe) else $error("pin enables differ from mode");
    a_ws_fall: assert property (p_ws_fall) else $error("word select off a fall");
    a_half: assert property (p_half) else $error("half frame length wrong");
    a_sdo_fall: assert property (p_sdo_fall) else $error("data moved off a fall");
    a_phase: assert property (p_phase) else $error("bit clock phase short");
    a_take: assert property (p_take) else $error("sample not taken");
    a_pair: assert property (p_pair) else $error("pair not completed");
    a_pad: assert property (p_pad) else $error("pad slot not zero");
endmodule : i2s_audio_properties

bind i2s_audio_port i2s_audio_properties #(.PORTS(PORTS)) u_props (
    .clock(clock), .srst(srst), .cfg(cfg), .tx_taken(tx_taken),
    .rx_valid(rx_valid), .sck_out(sck_out), .sck_oe(sck_oe),
    .ws_out(ws_out), .ws_oe(ws_oe), .sdo(sdo)
);

/* codec_model.sv */
// Behavioural external codec that masters the bit clock of a slave port.
// Assumes the system clock as time base; the bit clock stops while en is low.
`timescale 1ns/1ps
module codec_model #(
    parameter int HALF_CYC = 8
) (
    input wire logic clock,
    input wire logic en,
    input wire i2s_audio_pkg::stereo_s tx_pair,
    input wire logic sdo,
    output logic sck,
    output logic ws,
    output logic sdi,
    output i2s_audio_pkg::stereo_s rx_pair
);
    logic [31:0] word;
    logic [31:0] rx_w;
    int k;
    // One stereo frame per pass: data and word select move on falls.
    initial begin
        sck = 1'b0;
        ws = 1'b1;
        sdi = 1'b0;
        rx_pair = '0;
        rx_w = '0;
        forever begin
            @(posedge clock);
            while (en) begin
                word = tx_pair;
                for (k = 0; k < 32; k++) begin
                    sck <= 1'b0;
                    sdi <= word[31-k];
                    ws <= (((k + 1) % 32) >= 16);
                    repeat (HALF_CYC) @(posedge clock);
                    sck <= 1'b1;
                    rx_w = {rx_w[30:0], sdo};
                    repeat (HALF_CYC) @(posedge clock);
                end
                rx_pair <= rx_w;
            end
        end
    end
endmodule : codec_model

/* testbench.sv */
// Bench for the dual audio port: port 0 master with data looped back,
// port 1 slave to a behavioural codec; pin levels are resolved here.
`timescale 1ns/1ps
module testbench;
    logic clock, srst, far_en, far_sck, far_ws, far_sdi;
    i2s_audio_pkg::port_cfg_s [1:0] cfg;
    i2s_audio_pkg::stereo_s [1:0] tx_sample, rx_sample;
    i2s_audio_pkg::stereo_s far_tx, far_rx;
    logic [1:0] tx_taken, rx_valid, sck_in, sck_out, sck_oe, ws_in, ws_out, ws_oe, sdi, sdo;
    int bad_count;
    int n_compared;
    // Port 1 clock and word select carry whichever party enables its driver; port 0 pins loop back.
    assign sck_in = {sck_oe[1] ? sck_out[1] : far_sck, sck_out[0]};
    assign ws_in = {ws_oe[1] ? ws_out[1] : far_ws, ws_out[0]};
    assign sdi = {far_sdi, sdo[0]};
    i2s_audio_port u_i2s_audio_port (.clock(clock), .srst(srst), .cfg(cfg),
        .tx_sample(tx_sample), .tx_taken(tx_taken), .rx_sample(rx_sample),
        .rx_valid(rx_valid), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .ws_in(ws_in), .ws_out(ws_out), .ws_oe(ws_oe), .sdi(sdi), .sdo(sdo));
    codec_model u_codec_model (.clock(clock), .en(far_en), .tx_pair(far_tx),
        .sdo(sdo[1]), .sck(far_sck), .ws(far_ws), .sdi(far_sdi), .rx_pair(far_rx));
    // Free-running 25 MHz system clock.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic stop_test();
        $display("Counts: %0d compared, %0d mismatched", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic do_reset();
        srst = 1'b1;
        repeat (20) @(negedge clock);
        srst = 1'b0;
    endtask : do_reset
    // Waits for n result pulses of port p under a bounded count.
    task automatic wait_valid(input int p, input int n);
        int i;
        for (i = 0; i < 5000 && n > 0; i++) begin
            @(negedge clock);
            if (rx_valid[p] === 1'b1) n--;
        end
        if (n > 0) begin
            bad_count++;
            stop_test();
        end
    endtask : wait_valid
    // Counts cycles and bit clock rises up to the next word select rise.
    task automatic ws_rise(output int cyc, output int rises);
        logic ws_p;
        logic sck_p;
        ws_p = ws_out[0];
        cyc = 0;
        rises = 0;
        while (!(ws_out[0] === 1'b1 && ws_p === 1'b0)) begin
            ws_p = ws_out[0];
            sck_p = sck_out[0];
            @(negedge clock);
            cyc++;
            rises += int'(sck_out[0] === 1'b1 && sck_p === 1'b0);
            if (cyc > 2000) begin
                bad_count++;
                stop_test();
            end
        end
    endtask : ws_rise
    task automatic t_reset_values();
        repeat (20) @(negedge clock);
        check(32'({sck_out, ws_out, sdo, rx_valid, tx_taken}), 32'h0, "reset pins");
        check(rx_sample[0], 32'h0, "reset sample 0");
        check(rx_sample[1], 32'h0, "reset sample 1");
        check(32'({ws_oe, sck_oe}), 32'h5, "enables in reset");
        srst = 1'b0;
    endtask : t_reset_values
    task automatic t_master(input logic long_mode);
        int cyc;
        int rises;
        cfg[0] = {1'b1, long_mode};
        do_reset();
        ws_rise(cyc, rises);
        ws_rise(cyc, rises);
        check(32'(cyc >= 520 && cyc <= 521), 32'h1, "frame period");
        check(32'(rises), long_mode ? 32'h32 : 32'h20, "clocks per frame");
        wait_valid(0, 2);
        check(rx_sample[0], tx_sample[0], "loopback pair");
    endtask : t_master
    task automatic t_slave();
        cfg = 4'h2;
        do_reset();
        far_en = 1'b1;
        wait_valid(1, 4);
        check(rx_sample[1], far_tx, "slave receive");
        check(far_rx, tx_sample[1], "slave send");
        check(32'({ws_oe[1], sck_oe[1]}), 32'h0, "slave pins input");
        check(rx_sample[0], tx_sample[0], "other port intact");
        far_en = 1'b0;
    endtask : t_slave
    // Main sequence.
    initial begin
        srst = 1'b1;
        cfg = 4'h2;
        tx_sample = {32'h8001_7ffe, 32'ha51c_3e07};
        far_tx = 32'h96f0_0f69;
        far_en = 1'b0;
        bad_count = 0;
        n_compared = 0;
        t_reset_values();
        t_master(1'b0);
        t_master(1'b1);
        t_slave();
        stop_test();
    end
endmodule : testbench
